/* rtl/ext_port_pkg.sv */
package ext_port_pkg;
	localparam int DATA_W = 24;
	localparam int ADDR_W = 24;
	localparam int REGIONS = 4;
	// I/O space addresses of the control registers
	localparam logic [23:0] ADDR_REGION0 = 24'hffff79;
	localparam logic [23:0] ADDR_REGION1 = 24'hffff78;
	localparam logic [23:0] ADDR_REGION2 = 24'hffff77;
	localparam logic [23:0] ADDR_REGION3 = 24'hffff6f;
	localparam logic [23:0] ADDR_WAIT = 24'hfffffb;
	localparam logic [23:0] ADDR_PLL = 24'hfffffd;
	// Region decode fields
	localparam int RD_TYPE_LO = 0;
	localparam int RD_POL = 2;
	localparam int RD_P_EN = 3;
	localparam int RD_X_EN = 4;
	localparam int RD_Y_EN = 5;
	localparam int RD_SWAP = 6;
	localparam int RD_PACK = 7;
	localparam int RD_NBITS_LO = 8;
	localparam int RD_BASE_LO = 12;
	localparam logic [1:0] TYPE_ASYNC_SRAM = 2'h1;
	// Wait-state control fields
	localparam int WS0_LO = 0;
	localparam int WS1_LO = 5;
	localparam int WS2_LO = 10;
	localparam int WS3_LO = 13;
	localparam int WSD_LO = 16;
	localparam int BUS_STATE_BIT = 21;
	localparam int LOCK_HOLD_BIT = 22;
	localparam int REQ_HOLD_BIT = 23;
	// Operating mode fields
	localparam int OM_MODE_LO = 0;
	localparam int OM_EXT_DIS = 4;
	localparam int OM_MEM_SWAP = 7;
	localparam int OM_ACK_SYNC = 11;
	localparam int OM_BUS_REL = 12;
	localparam int OM_PRIO_DIS = 14;
	// Status fields
	localparam int ST_COMPAT16 = 13;
	localparam int ST_CACHE_EN = 19;
	// PLL control fields
	localparam int PLL_MF_LO = 0;
	localparam int PLL_DF_LO = 12;
	localparam int PLL_SLOW_XTAL = 15;
	localparam int PLL_XTAL_DIS = 16;
	localparam int PLL_STOP_RUN = 17;
	localparam int PLL_EN = 18;
	localparam int PLL_CLKOUT_DIS = 19;
	localparam int PLL_PD_LO = 20;
	// Reset values
	localparam logic [23:0] RST_ZERO = 24'h000000;
	localparam logic [23:0] RST_STATUS = 24'h080000;
	// Memory spaces
	typedef enum logic [1:0] {SPACE_P, SPACE_X, SPACE_Y, SPACE_NONE} space_t;
	// Timing
	localparam real CLK_NS = 4.0;
	localparam int WAIT_W = 5;
endpackage

/* rtl/ext_port_cfg.sv */
`timescale 1ns/1ps
// What this block does
// - Region type field bits 0-1, 1=async SRAM
// - Bit 2 sets select pin polarity
// - Bits 3-5 enable P, X, Y spaces
// - Bit 6 swaps low byte onto top
// - Bit 7 enables DMA packing for region
// - Bits 8-11 give compare bit count
// - Bits 12-23 hold compare base address
// - Nine bits, base 0x100 selects SRAM low
// - Ten bits, base 0x104 high drives A14
// - Wait counts regions 0-2 in bits 0-12
// - Region 3 and default wait counts
// - Bus state, lock hold, request hold bits
// - One wait at 80 MHz allows 12.4ns
// - Mode bits, bus disable, memory swap
// - Ack sync select, bus release timing
// - Bit 14 lets select pins assert together
// - Status bit 19 enables instruction cache
// - Status bit 13 compat; reset 0x080000
// - PLL multiplier bits 0-11, factor minus one
// - Predivider 20-23, divider 12-14, minus one
// - PLL bits 15-19 control crystal and clock
// - Select needs address and space match
// - Core clock = in*MF/(PD*DF)
module ext_port_cfg
	import ext_port_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control register write port (I/O space)
	input wire logic cfg_wr,
	input wire logic [ext_port_pkg::ADDR_W-1:0] cfg_addr,
	input wire logic [ext_port_pkg::DATA_W-1:0] cfg_wdata,
	output logic [ext_port_pkg::DATA_W-1:0] cfg_rdata,
	// Core-written mode and status registers, plus the PLL control register output
	input wire logic omr_wr,
	input wire logic [ext_port_pkg::DATA_W-1:0] omr_wdata,
	input wire logic sr_wr,
	input wire logic [ext_port_pkg::DATA_W-1:0] sr_wdata,
	output logic [ext_port_pkg::DATA_W-1:0] operating_mode_control,
	output logic [ext_port_pkg::DATA_W-1:0] core_status_control,
	output logic [ext_port_pkg::DATA_W-1:0] pll_clock_control,
	// External access request
	input wire logic acc_req,
	input wire logic acc_write,
	input wire ext_port_pkg::space_t acc_space,
	input wire logic [ext_port_pkg::ADDR_W-1:0] acc_addr,
	input wire logic bus_busy_in,
	output logic acc_done,
	// External bus
	output logic [ext_port_pkg::ADDR_W-1:0] ext_addr,
	output logic [REGIONS-1:0] region_select_pins,
	output logic ext_rd_n,
	output logic ext_wr_n,
	output logic bus_state_o,
	output logic cache_en_o,
	output logic ext_bus_dis_o
);
	import ext_port_pkg::*;

	typedef enum {ST_IDLE, ST_STROBE, ST_END} acc_state_t;

	logic [DATA_W-1:0] region_ff [REGIONS];
	logic [DATA_W-1:0] wait_ff;
	logic [DATA_W-1:0] pll_ff;
	logic [DATA_W-1:0] omr_ff;
	logic [DATA_W-1:0] sr_ff;
	logic busy_meta_ff, busy_sync_ff;
	logic [REGIONS-1:0] hit;
	logic [REGIONS-1:0] sel_raw;
	logic [REGIONS-1:0] nxt_sel;
	logic [WAIT_W-1:0] nxt_wait;
	logic [WAIT_W-1:0] wait_cnt_ff;
	acc_state_t state_ff;
	logic [ADDR_W-1:0] nxt_addr;
	logic take;
	logic [REGIONS-1:0] swap_en;
	logic [REGIONS-1:0] pol_en;

	// Bus busy pin comes from outside; double-sync before use
	always_ff @(posedge core_clk) begin
		if (rst) begin
			busy_meta_ff <= 1'b0;
			busy_sync_ff <= 1'b0;
		end else begin
			busy_meta_ff <= bus_busy_in;
			busy_sync_ff <= busy_meta_ff;
		end
	end

	// Region decode registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < REGIONS; i++) begin
				region_ff[i] <= RST_ZERO;
			end
		end else if (cfg_wr) begin
			if (cfg_addr == ADDR_REGION0) region_ff[0] <= cfg_wdata;
			if (cfg_addr == ADDR_REGION1) region_ff[1] <= cfg_wdata;
			if (cfg_addr == ADDR_REGION2) region_ff[2] <= cfg_wdata;
			if (cfg_addr == ADDR_REGION3) region_ff[3] <= cfg_wdata;
		end
	end

	// Wait-state control; bus state bit is hardware-owned status
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wait_ff <= RST_ZERO;
		end else begin
			if (cfg_wr && cfg_addr == ADDR_WAIT) begin
				wait_ff <= cfg_wdata;
			end
			wait_ff[BUS_STATE_BIT] <= busy_sync_ff;
		end
	end

	// PLL control: MF, DF, PD fields hold ratio minus one
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pll_ff <= RST_ZERO;
		end else if (cfg_wr && cfg_addr == ADDR_PLL) begin
			pll_ff <= cfg_wdata;
		end
	end

	// Mode and status registers written by the core
	always_ff @(posedge core_clk) begin
		if (rst) begin
			omr_ff <= RST_ZERO;
			sr_ff <= RST_STATUS;
		end else begin
			if (omr_wr) omr_ff <= omr_wdata;
			if (sr_wr) sr_ff <= sr_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_rdata <= RST_ZERO;
		end else begin
			case (cfg_addr)
				ADDR_REGION0: cfg_rdata <= region_ff[0];
				ADDR_REGION1: cfg_rdata <= region_ff[1];
				ADDR_REGION2: cfg_rdata <= region_ff[2];
				ADDR_REGION3: cfg_rdata <= region_ff[3];
				ADDR_WAIT: cfg_rdata <= wait_ff;
				ADDR_PLL: cfg_rdata <= pll_ff;
				default: cfg_rdata <= RST_ZERO;
			endcase
		end
	end

	// Per-region address and space match
	generate
		for (genvar g = 0; g < REGIONS; g++) begin : g_region
			logic [11:0] mask;
			logic [3:0] nbits;
			logic space_ok;
			always_comb begin
				nbits = region_ff[g][RD_NBITS_LO +: 4];
				mask = 12'h000;
				for (int b = 0; b < 12; b++) begin
					if (b >= 12 - int'(nbits)) mask[b] = 1'b1;
				end
				case (acc_space)
					SPACE_P: space_ok = region_ff[g][RD_P_EN];
					SPACE_X: space_ok = region_ff[g][RD_X_EN];
					SPACE_Y: space_ok = region_ff[g][RD_Y_EN];
					default: space_ok = 1'b0;
				endcase
				// Address compare against base; covers the 0x100/0x104 examples
				hit[g] = space_ok && ((acc_addr[23:12] & mask) ==
					(region_ff[g][RD_BASE_LO +: 12] & mask));
			end
		end
	endgenerate

	// Lowest region number wins unless priority is disabled
	always_comb begin
		sel_raw = hit;
		if (!omr_ff[OM_PRIO_DIS]) begin
			for (int i = REGIONS - 1; i >= 0; i--) begin
				if (hit[i]) sel_raw = 4'(1 << i);
			end
		end
		if (omr_ff[OM_EXT_DIS]) sel_raw = 4'h0;
	end

	// Pin levels: polarity bit set means high on match
	always_comb begin
		for (int i = 0; i < REGIONS; i++) begin
			nxt_sel[i] = region_ff[i][RD_POL] ? sel_raw[i] : ~sel_raw[i];
		end
	end

	// Wait count from the selected region, else default count
	always_comb begin
		if (sel_raw[0]) nxt_wait = wait_ff[WS0_LO +: 5];
		else if (sel_raw[1]) nxt_wait = wait_ff[WS1_LO +: 5];
		else if (sel_raw[2]) nxt_wait = {2'h0, wait_ff[WS2_LO +: 3]};
		else if (sel_raw[3]) nxt_wait = {2'h0, wait_ff[WS3_LO +: 3]};
		else nxt_wait = wait_ff[WSD_LO +: 5];
	end

	// Address byte swap when the hit region asks for it
	always_comb begin
		nxt_addr = acc_addr;
		for (int i = 0; i < REGIONS; i++) begin
			if (sel_raw[i] && region_ff[i][RD_SWAP]) begin
				nxt_addr = {acc_addr[7:0], acc_addr[15:0]};
			end
		end
	end

	// An access is taken only from idle with the external bus enabled
	assign take = state_ff == ST_IDLE && acc_req && !omr_ff[OM_EXT_DIS];

	// Per-region swap and polarity bits gathered for the checks below
	always_comb begin
		for (int i = 0; i < REGIONS; i++) begin
			swap_en[i] = region_ff[i][RD_SWAP];
			pol_en[i] = region_ff[i][RD_POL];
		end
	end

	// Access sequencer: one strobe cycle plus one per wait state
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			wait_cnt_ff <= '0;
			ext_rd_n <= 1'b1;
			ext_wr_n <= 1'b1;
			acc_done <= 1'b0;
			ext_addr <= RST_ZERO;
			// Regions reset to low-active, so every select idles high
			region_select_pins <= 4'hf;
		end else begin
			acc_done <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					for (int i = 0; i < REGIONS; i++) begin
						region_select_pins[i] <= ~region_ff[i][RD_POL];
					end
					if (acc_req && !omr_ff[OM_EXT_DIS]) begin
						ext_addr <= nxt_addr;
						region_select_pins <= nxt_sel;
						wait_cnt_ff <= nxt_wait;
						ext_rd_n <= acc_write;
						ext_wr_n <= ~acc_write;
						state_ff <= ST_STROBE;
					end
				end
				ST_STROBE: begin
					if (wait_cnt_ff == '0) begin
						ext_rd_n <= 1'b1;
						ext_wr_n <= 1'b1;
						acc_done <= 1'b1;
						state_ff <= ST_END;
					end else begin
						wait_cnt_ff <= wait_cnt_ff - 1'b1;
					end
				end
				ST_END: begin
					for (int i = 0; i < REGIONS; i++) begin
						region_select_pins[i] <= ~region_ff[i][RD_POL];
					end
					state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Registered status outputs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			operating_mode_control <= RST_ZERO;
			core_status_control <= RST_STATUS;
			pll_clock_control <= RST_ZERO;
			bus_state_o <= 1'b0;
			cache_en_o <= 1'b0;
			ext_bus_dis_o <= 1'b0;
		end else begin
			operating_mode_control <= omr_ff;
			core_status_control <= sr_ff;
			pll_clock_control <= pll_ff;
			bus_state_o <= wait_ff[BUS_STATE_BIT];
			cache_en_o <= sr_ff[ST_CACHE_EN];
			ext_bus_dis_o <= omr_ff[OM_EXT_DIS];
		end
	end

	// Region type and packing bits are stored for the DMA and type logic elsewhere

	// Access timing checks
	// One cycle with either strobe low
	sequence s_strobe;
		!ext_rd_n || !ext_wr_n;
	endsequence

	sequence s_start;
		state_ff == ST_IDLE && acc_req && !omr_ff[OM_EXT_DIS] && nxt_wait == 5'h1;
	endsequence

	sequence s_start_nowait;
		take && nxt_wait == 5'h0;
	endsequence

	// Strobes rise with the done pulse so the bus is quiet between accesses
	sequence s_finish;
		acc_done && ext_rd_n && ext_wr_n;
	endsequence

	AST_ONE_WAIT: assert property (@(posedge core_clk) disable iff (rst)
		s_start |=> s_strobe ##1 s_strobe ##1 s_finish)
		else $error("one wait state access not two strobe cycles");
	AST_ZERO_WAIT: assert property (@(posedge core_clk) disable iff (rst)
		s_start_nowait |=> s_strobe ##1 s_finish)
		else $error("zero wait state access not one strobe cycle");
	AST_DONE_PULSE: assert property (@(posedge core_clk) disable iff (rst)
		acc_done |=> !acc_done)
		else $error("done held longer than one cycle");
	AST_SR_RESET: assert property (@(posedge core_clk)
		$past(rst) |-> sr_ff == RST_STATUS)
		else $error("status not at reset value after reset");
	AST_SEL_POL: assert property (@(posedge core_clk) disable iff (rst)
		state_ff == ST_IDLE && acc_req && !omr_ff[OM_EXT_DIS] && sel_raw[3]
		|=> region_select_pins[3] == region_ff[3][RD_POL])
		else $error("select pin polarity wrong");
	AST_NO_SPACE: assert property (@(posedge core_clk) disable iff (rst)
		acc_space == SPACE_NONE |-> hit == 4'h0)
		else $error("select without enabled space");
	AST_PRIO: assert property (@(posedge core_clk) disable iff (rst)
		!omr_ff[OM_PRIO_DIS] |-> $onehot0(sel_raw))
		else $error("two selects with priority on");
	AST_CACHE: assert property (@(posedge core_clk) disable iff (rst)
		sr_wr |-> ##2 cache_en_o == $past(sr_wdata[ST_CACHE_EN], 2))
		else $error("cache enable not following status");
	AST_BUS_DIS: assert property (@(posedge core_clk) disable iff (rst)
		omr_ff[OM_EXT_DIS] && state_ff == ST_IDLE |=> state_ff == ST_IDLE)
		else $error("access started with bus disabled");
	AST_PLL: assert property (@(posedge core_clk) disable iff (rst)
		cfg_wr && cfg_addr == ADDR_PLL |=> pll_ff[11:0] == $past(cfg_wdata[11:0]))
		else $error("multiplier field not stored");

	// Select and address checks
	AST_SEL_HOLD: assert property (@(posedge core_clk) disable iff (rst)
		state_ff == ST_STROBE |=> $stable(region_select_pins) && $stable(ext_addr))
		else $error("select or address moved during strobe");
	AST_IDLE_LEVEL: assert property (@(posedge core_clk) disable iff (rst)
		state_ff == ST_END |=> region_select_pins == ~$past(pol_en))
		else $error("select not back at inactive level");
	AST_SWAP: assert property (@(posedge core_clk) disable iff (rst)
		take && (sel_raw & swap_en) != 4'h0 |=> ext_addr[23:16] == $past(acc_addr[7:0]))
		else $error("low address byte not moved to top lines");
	AST_NO_SWAP: assert property (@(posedge core_clk) disable iff (rst)
		take && (sel_raw & swap_en) == 4'h0 |=> ext_addr == $past(acc_addr))
		else $error("address changed without swap");

	// Register and status checks
	AST_DEFAULT_WAIT: assert property (@(posedge core_clk) disable iff (rst)
		take && sel_raw == 4'h0 |=> wait_cnt_ff == $past(wait_ff[WSD_LO +: 5]))
		else $error("unmatched access not using default wait count");
	AST_BUS_STATE: assert property (@(posedge core_clk) disable iff (rst)
		wait_ff[BUS_STATE_BIT] == $past(busy_sync_ff))
		else $error("bus state flag not following bus busy pin");
	AST_EXT_DIS_OUT: assert property (@(posedge core_clk) disable iff (rst)
		ext_bus_dis_o == $past(omr_ff[OM_EXT_DIS]))
		else $error("bus disable output not following mode bit");
	AST_REGION_STORE: assert property (@(posedge core_clk) disable iff (rst)
		cfg_wr && cfg_addr == ADDR_REGION3 |=> region_ff[3] == $past(cfg_wdata))
		else $error("region decode word not stored");
endmodule

/* sim/sram_bank_model.sv */
`timescale 1ns/1ps
module sram_bank_model (
	// Bus side
	input wire logic core_clk,
	input wire logic [23:0] ext_addr,
	input wire logic [3:0] region_select_pins,
	input wire logic ext_rd_n,
	input wire logic ext_wr_n,
	// Last completed access as the bank saw it
	output int strobe_cycles,
	output logic [14:0] row_addr
);
	int run;
	initial begin
		run = 0;
		strobe_cycles = 0;
		row_addr = 15'h0;
	end
	// Bank only responds while its enable is low and a strobe is low
	// Strobe width gives the access time granted to the part
	always @(posedge core_clk) begin
		if (!region_select_pins[3] && !(ext_rd_n && ext_wr_n)) begin
			run = run + 1;
			row_addr = {region_select_pins[2], ext_addr[13:0]};
		end else if (run != 0) begin
			strobe_cycles = run;
			run = 0;
		end
	end
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import ext_port_pkg::*;
	logic core_clk = 0, rst = 1, cfg_wr = 0, omr_wr = 0, sr_wr = 0;
	logic acc_req = 0, acc_write = 0, bus_busy_in = 0;
	logic [23:0] cfg_addr = 24'h0, cfg_wdata = 24'h0, omr_wdata = 24'h0, sr_wdata = 24'h0;
	logic [23:0] acc_addr = 24'h0, cfg_rdata, operating_mode_control, core_status_control;
	logic [23:0] pll_clock_control, ext_addr;
	logic [3:0] region_select_pins;
	logic acc_done, ext_rd_n, ext_wr_n, bus_state_o, cache_en_o, ext_bus_dis_o;
	space_t acc_space = SPACE_P;
	int strobe_cycles, fail_count = 0, checks = 0, seed = 32'h5bef;
	logic [14:0] row_addr;
	logic prio_on = 1;
	// Reference copies of the programmed registers
	logic [23:0] rg[4] = '{24'h0, 24'h0, 24'h104a0d, 24'h100909};
	logic [23:0] wait_reg = 24'h032400;
	int lo[4] = '{WS0_LO, WS1_LO, WS2_LO, WS3_LO};
	int wm[4] = '{31, 31, 7, 7};
	logic [23:0] ra[6] = '{ADDR_REGION0, ADDR_REGION1, ADDR_REGION2, ADDR_REGION3,
		ADDR_WAIT, ADDR_PLL};
	logic [23:0] rv[6] = '{24'h0, 24'h0, 24'h104a0d, 24'h100909, 24'h032400, 24'h0e0013};
	ext_port_cfg ext_port_cfg_i (.core_clk(core_clk), .rst(rst), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .omr_wr(omr_wr),
		.omr_wdata(omr_wdata), .sr_wr(sr_wr), .sr_wdata(sr_wdata),
		.operating_mode_control(operating_mode_control),
		.core_status_control(core_status_control), .pll_clock_control(pll_clock_control),
		.acc_req(acc_req), .acc_write(acc_write), .acc_space(acc_space), .acc_addr(acc_addr),
		.bus_busy_in(bus_busy_in), .acc_done(acc_done), .ext_addr(ext_addr),
		.region_select_pins(region_select_pins), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
		.bus_state_o(bus_state_o), .cache_en_o(cache_en_o), .ext_bus_dis_o(ext_bus_dis_o));
	sram_bank_model sram_bank_model_i (.core_clk(core_clk), .ext_addr(ext_addr),
		.region_select_pins(region_select_pins), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
		.strobe_cycles(strobe_cycles), .row_addr(row_addr));
	always #2 core_clk = ~core_clk;
	task automatic close_out();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(logic [23:0] seen, logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	task automatic wr_cfg(logic [23:0] a, logic [23:0] d);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr = 1;
		tick();
		cfg_wr = 0;
		tick();
	endtask
	task automatic set_omr(logic [23:0] d);
		omr_wdata = d;
		omr_wr = 1;
		tick();
		omr_wr = 0;
		tick();
	endtask
	task automatic rd_chk(logic [23:0] a, logic [23:0] exp);
		cfg_addr = a;
		tick();
		tick();
		check(cfg_rdata, exp);
	endtask
	// Compare width counts from the top of the address, capped at twelve bits
	function automatic logic hit(logic [23:0] r, logic [23:0] a, int s);
		int n;
		n = r[11:8];
		if (n > 12) n = 12;
		return r[3 + s] && (n == 0 || (a >> (24 - n)) == (r[23:12] >> (12 - n)));
	endfunction
	function automatic int exp_wait(logic [23:0] a, int s);
		for (int i = 0; i < 4; i++) begin
			if (hit(rg[i], a, s)) return (wait_reg >> lo[i]) & wm[i];
		end
		return (wait_reg >> WSD_LO) & 31;
	endfunction
	task automatic access(logic [23:0] a, int s, logic w);
		int n;
		int ws;
		logic taken;
		logic [3:0] pins, sel;
		logic [23:0] ea;
		ws = exp_wait(a, s);
		ea = a;
		taken = 0;
		// With priority on only the lowest matching region drives its pin
		for (int i = 0; i < 4; i++) begin
			sel[i] = hit(rg[i], a, s) && !(prio_on && taken);
			taken = taken | sel[i];
			pins[i] = sel[i] ? rg[i][RD_POL] : !rg[i][RD_POL];
			if (sel[i] && rg[i][RD_SWAP]) ea = {a[7:0], a[15:0]};
		end
		acc_addr = a;
		acc_space = space_t'(s);
		acc_write = w;
		acc_req = 1;
		for (n = 0; n < 8 && ext_rd_n === 1'b1 && ext_wr_n === 1'b1; n++) tick();
		acc_req = 0;
		if (n == 8) begin
			fail_count++;
			close_out();
		end
		check(region_select_pins, pins);
		check(w ? ext_wr_n : ext_rd_n, 1'b0);
		check(ext_addr, ea);
		for (n = 0; n < 40 && acc_done !== 1'b1; n++) tick();
		if (n == 40) begin
			fail_count++;
			close_out();
		end
		check(24'(n), 24'(1 + ws));
		repeat (3) tick();
		if (!pins[3]) begin
			check(24'(strobe_cycles), 24'(1 + ws));
			check(row_addr, a[14:0]);
		end
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		#1;
		rst = 0;
		check(core_status_control, RST_STATUS);
		check(pll_clock_control, 24'h0);
		for (int i = 0; i < 6; i++) wr_cfg(ra[i], rv[i]);
		for (int i = 0; i < 6; i++) rd_chk(ra[i], rv[i]);
		rd_chk(24'hfffff0, 24'h0);
		check(pll_clock_control, 24'h0e0013);
		omr_wdata = 24'h004000;
		sr_wdata = 24'h082000;
		omr_wr = 1;
		sr_wr = 1;
		tick();
		omr_wr = 0;
		sr_wr = 0;
		tick();
		check(operating_mode_control, 24'h004000);
		check(core_status_control, 24'h082000);
		check(cache_en_o, 1'b1);
		prio_on = 0;
		foreach (rv[i]) begin
			for (int s = 0; s < 3; s++) begin
				access(24'h100000 + 24'(i) * 24'h1fff, s, s[0]);
			end
		end
		access(24'h108000, 0, 0);
		for (int k = 0; k < 24; k++) begin
			access(24'h100000 + 24'($random(seed) & 32'h7fff), $unsigned($random(seed)) % 3,
				k[0]);
		end
		// Region 1: X space, any address, low byte moved to the top lines
		rg[1] = 24'h000051;
		wr_cfg(ADDR_REGION1, rg[1]);
		access(24'h1234ab, 1, 1);
		set_omr(24'h000000);
		prio_on = 1;
		access(24'h105000, 0, 0);
		access(24'h101000, 0, 1);
		bus_busy_in = 1;
		repeat (4) tick();
		rd_chk(ADDR_WAIT, 24'h232400);
		check(bus_state_o, 1'b1);
		set_omr(24'h004010);
		check(ext_bus_dis_o, 1'b1);
		acc_addr = 24'h100000;
		acc_req = 1;
		repeat (6) begin
			tick();
			check(ext_rd_n & ext_wr_n, 1'b1);
		end
		acc_req = 0;
		close_out();
	end
endmodule
